// ===== core/rtc_control_and_interrupt.v
`timescale 1ns/1ps
`default_nettype none
`include "rtc_ctrl_consts.vh"

module rtc_control_and_interrupt (
  // System clock and reset.
  input  wire        clk,
  input  wire        rst_n,
  // Register port from the serial interface decoder.
  input  wire [3:0]  reg_addr,
  input  wire [7:0]  reg_wdata,
  input  wire        reg_we,
  output reg  [7:0]  reg_rdata,
  // Crystal and oscillator detector pins.
  input  wire        xtal_in,
  input  wire        osc_running,
  // Time counter status from the counter block.
  input  wire        sec_tick,
  input  wire [7:0]  sec_value,
  input  wire [7:0]  min_value,
  input  wire [7:0]  hour_value,
  input  wire [7:0]  day_value,
  input  wire        alarm_one_match,
  input  wire        alarm_two_match,
  // Controls to the counter and trimming blocks.
  output reg         hour_24_mode,
  output reg         crystal_select,
  output reg  [6:0]  trim_code,
  output reg         test_mode,
  output reg         prescaler_clear,
  output reg         seconds_zero,
  output reg         minute_inc,
  // Pins.
  output reg         irq_out_n,
  output reg         crystal_clock_out
);

  // Lag in crystal cycles; microseconds first so the product stays inside 32 bits.
  localparam integer LAG_A_CYC = ((`LAG_NS_A / 1000) * `XTAL_HZ_A) / 1000000;
  localparam integer LAG_B_CYC = ((`LAG_NS_B / 1000) * `XTAL_HZ_B) / 1000000;
  localparam [14:0]  LAG_A     = LAG_A_CYC[14:0];
  localparam [14:0]  LAG_B     = LAG_B_CYC[14:0];

  // Control state.
  reg [2:0]  irq_period_sel;
  reg        alarm_one_enable;
  reg        alarm_two_enable;
  reg        clock_out_off;
  reg        osc_halt_flag;
  reg        alarm_one_flag;
  reg        alarm_two_flag;
  reg        level_flag;
  reg        level_pending;
  reg        periodic_held;
  // Pin synchronisers.
  reg        xtal_meta;
  reg        xtal_sync;
  reg        xtal_prev;
  reg        osc_meta;
  reg        osc_sync;
  // Crystal-cycle phase within the current second.
  reg [14:0] phase;

  wire       xtal_rise = xtal_sync & ~xtal_prev;
  wire       write_c1  = reg_we && (reg_addr == `ADDR_CTRL_ONE);
  wire       write_c2  = reg_we && (reg_addr == `ADDR_CTRL_TWO);
  wire       write_tr  = reg_we && (reg_addr == `ADDR_TRIM);
  wire       adj_req   = write_c2 && reg_wdata[`C2_ADJ_HALT];
  wire       level_mode = irq_period_sel[`C1_PERIOD_HI];

  // Thresholds follow the crystal choice so 32.000kHz gives 0.496s/0.504s halves.
  wire [14:0] lag    = crystal_select ? LAG_B : LAG_A;
  wire [14:0] qtr    = lag + (crystal_select ? `QTR_B : `QTR_A);
  wire [14:0] half   = lag + (crystal_select ? `HALF_B : `HALF_A);
  wire [14:0] qtr3   = lag + (crystal_select ? `QTR3_B : `QTR3_A);
  wire [14:0] period = crystal_select ? `PERIOD_B : `PERIOD_A;

  // Two flops on each pin before any logic looks at it.
  always @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      xtal_meta <= 1'b0;
      xtal_sync <= 1'b0;
      xtal_prev <= 1'b0;
      osc_meta  <= 1'b0;
      osc_sync  <= 1'b0;
    end else begin
      xtal_meta <= xtal_in;
      xtal_sync <= xtal_meta;
      xtal_prev <= xtal_sync;
      osc_meta  <= osc_running;
      osc_sync  <= osc_meta;
    end
  end

  // Phase restarts on each count-up so trimmed seconds move the waveform too.
  always @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      phase <= 15'h0000;
    end else if (sec_tick || adj_req) begin
      phase <= 15'h0000;
    end else if (xtal_rise) begin
      phase <= (phase == period) ? 15'h0000 : phase + 15'h0001;
    end
  end

  // Pulse-mode output levels; the low window opens after the count-up lag.
  wire low_1hz = (phase >= lag) && (phase < half);
  wire low_2hz = ((phase >= lag) && (phase < qtr)) ||
                 ((phase >= half) && (phase < qtr3));
  wire lag_hit = xtal_rise && (phase == lag);

  // Level-mode condition checked on the new counter values at count-up.
  reg level_cond;
  always @* begin
    case (irq_period_sel)
      `PER_SEC:   level_cond = 1'b1;
      `PER_MIN:   level_cond = (sec_value == `BCD_ZERO);
      `PER_HOUR:  level_cond = (sec_value == `BCD_ZERO) && (min_value == `BCD_ZERO);
      `PER_MONTH: level_cond = (sec_value == `BCD_ZERO) && (min_value == `BCD_ZERO) &&
                               (hour_value == (hour_24_mode ? `BCD_ZERO : `BCD_AM12)) &&
                               (day_value == `BCD_DAY_ONE);
      default:    level_cond = 1'b0;
    endcase
  end

  // Periodic request, combining fixed, pulse and level forms.
  reg periodic_low;
  always @* begin
    case (irq_period_sel)
      `PER_OFF: periodic_low = 1'b0;
      `PER_LOW: periodic_low = 1'b1;
      `PER_2HZ: periodic_low = low_2hz;
      `PER_1HZ: periodic_low = low_1hz;
      default:  periodic_low = level_flag;
    endcase
  end

  // Level-mode flag: armed at count-up, falls low after the lag, cleared by zero.
  always @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      level_pending <= 1'b0;
      level_flag    <= 1'b0;
    end else if (!level_mode) begin
      level_pending <= 1'b0;
      level_flag    <= 1'b0;
    end else begin
      if (sec_tick && level_cond) begin
        level_pending <= 1'b1;
      end else if (lag_hit) begin
        level_pending <= 1'b0;
      end
      // The set wins over a clear arriving in the same cycle.
      if (level_pending && lag_hit) begin
        level_flag <= 1'b1;
      end else if (write_c2 && !reg_wdata[`C2_PERIODIC_FG]) begin
        level_flag <= 1'b0;
      end
    end
  end

  // Halt flag: set from reset or a stopped oscillator, cleared by a control two write while running.
  always @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      osc_halt_flag <= 1'b1;
    end else if (!osc_sync) begin
      osc_halt_flag <= 1'b1;
    end else if (write_c2) begin
      osc_halt_flag <= 1'b0;
    end
  end

  // Configuration bits; while halted all but hour_24_mode are forced back to zero.
  always @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      irq_period_sel   <= 3'h0;
      alarm_one_enable <= 1'b0;
      alarm_two_enable <= 1'b0;
      test_mode        <= 1'b0;
      clock_out_off    <= 1'b0;
      crystal_select   <= 1'b0;
      trim_code        <= 7'h00;
      hour_24_mode     <= 1'b0;
    end else begin
      if (write_c2) begin
        hour_24_mode <= reg_wdata[`C2_HOUR_24];
      end
      if (osc_halt_flag) begin
        irq_period_sel   <= 3'h0;
        alarm_one_enable <= 1'b0;
        alarm_two_enable <= 1'b0;
        test_mode        <= 1'b0;
        clock_out_off    <= 1'b0;
        crystal_select   <= 1'b0;
        trim_code        <= 7'h00;
      end else begin
        if (write_c1) begin
          alarm_one_enable <= reg_wdata[`C1_ALARM_ONE_EN];
          alarm_two_enable <= reg_wdata[`C1_ALARM_TWO_EN];
          test_mode        <= reg_wdata[`C1_TEST];
          irq_period_sel   <= reg_wdata[`C1_PERIOD_HI:0];
        end
        if (write_c2) begin
          clock_out_off <= reg_wdata[`C2_CLK_OFF];
        end
        if (write_tr) begin
          crystal_select <= reg_wdata[`TR_XTAL_SEL];
          trim_code      <= reg_wdata[`TR_TRIM_HI:0];
        end
      end
    end
  end

  // Alarm flags: a match wins over a clear in the same cycle.
  always @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      alarm_one_flag <= 1'b0;
      alarm_two_flag <= 1'b0;
    end else begin
      if (!alarm_one_enable) begin
        alarm_one_flag <= 1'b0;
      end else if (alarm_one_match) begin
        alarm_one_flag <= 1'b1;
      end else if (write_c2 && !reg_wdata[`C2_ALARM_ONE_FG]) begin
        alarm_one_flag <= 1'b0;
      end
      if (!alarm_two_enable) begin
        alarm_two_flag <= 1'b0;
      end else if (alarm_two_match) begin
        alarm_two_flag <= 1'b1;
      end else if (write_c2 && !reg_wdata[`C2_ALARM_TWO_FG]) begin
        alarm_two_flag <= 1'b0;
      end
    end
  end

  // Seconds adjust pulses land one cycle after the write, far inside 122 us.
  always @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      prescaler_clear <= 1'b0;
      seconds_zero    <= 1'b0;
      minute_inc      <= 1'b0;
    end else begin
      prescaler_clear <= adj_req;
      seconds_zero    <= adj_req;
      minute_inc      <= adj_req && (sec_value >= `BCD_THIRTY);
    end
  end

  // Pins come straight from flops; the irq is an OR of every live source.
  always @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      irq_out_n         <= 1'b1;
      crystal_clock_out <= 1'b0;
      periodic_held     <= 1'b0;
    end else begin
      irq_out_n <= ~((periodic_low & ~osc_halt_flag) |
                     alarm_one_flag | alarm_two_flag);
      crystal_clock_out <= xtal_sync & ~clock_out_off;
      // The periodic flag moves with the pin, so a read never disagrees with it.
      periodic_held <= periodic_low & ~osc_halt_flag;
    end
  end

  // Read data; the adjust position returns the halt flag instead.
  always @* begin
    case (reg_addr)
      `ADDR_CTRL_ONE: reg_rdata = {alarm_one_enable, alarm_two_enable, 2'b00,
                                   test_mode, irq_period_sel};
      // A disabled alarm reads zero at once, before its flag has been cleared.
      `ADDR_CTRL_TWO: reg_rdata = {2'b00, hour_24_mode, osc_halt_flag,
                                   clock_out_off, periodic_held,
                                   alarm_one_flag & alarm_one_enable,
                                   alarm_two_flag & alarm_two_enable};
      `ADDR_TRIM:     reg_rdata = {crystal_select, trim_code};
      default:        reg_rdata = 8'h00;
    endcase
  end

endmodule
`default_nettype wire

// ===== core/rtc_ctrl_consts.vh
`ifndef RTC_CTRL_CONSTS_VH
`define RTC_CTRL_CONSTS_VH

// Internal register addresses.
`define ADDR_TRIM        4'h7
`define ADDR_CTRL_ONE    4'hE
`define ADDR_CTRL_TWO    4'hF

// Control register one fields.
`define C1_ALARM_ONE_EN  7
`define C1_ALARM_TWO_EN  6
`define C1_TEST          3
`define C1_PERIOD_HI     2

// Control register two fields.
`define C2_HOUR_24       5
`define C2_ADJ_HALT      4
`define C2_CLK_OFF       3
`define C2_PERIODIC_FG   2
`define C2_ALARM_ONE_FG  1
`define C2_ALARM_TWO_FG  0

// Trim register fields.
`define TR_XTAL_SEL      7
`define TR_TRIM_HI       6

// Period select codes.
`define PER_OFF          3'h0
`define PER_LOW          3'h1
`define PER_2HZ          3'h2
`define PER_1HZ          3'h3
`define PER_SEC          3'h4
`define PER_MIN          3'h5
`define PER_HOUR         3'h6
`define PER_MONTH        3'h7

// Crystal rates in hertz and the counts that shape the pulse waveforms.
`define XTAL_HZ_A        32768
`define XTAL_HZ_B        32000
`define QTR_A            15'h2000
`define HALF_A           15'h4000
`define QTR3_A           15'h6000
`define QTR_B            15'h1F00
`define HALF_B           15'h3E00
`define QTR3_B           15'h5D80
`define PERIOD_A         15'h7FFF
`define PERIOD_B         15'h7CFF

// Lag from seconds count-up to the interrupt falling edge, in nanoseconds.
`define LAG_NS_A         92000
`define LAG_NS_B         94000

// BCD values used by the level-mode conditions and the seconds rounding.
`define BCD_ZERO         8'h00
`define BCD_THIRTY       8'h30
`define BCD_DAY_ONE      8'h01
`define BCD_AM12         8'h12

`endif

// ===== testbench/rtc_ctrl_asserts.sv
`timescale 1ns/1ps
`default_nettype none
module rtc_ctrl_asserts (
  // Clock and reset.
  input wire logic       clk,
  input wire logic       rst_n,
  // Register port.
  input wire logic [3:0] reg_addr,
  input wire logic [7:0] reg_wdata,
  input wire logic       reg_we,
  input wire logic [7:0] reg_rdata,
  // Counter status.
  input wire logic       sec_tick,
  input wire logic [7:0] sec_value,
  // Outputs watched.
  input wire logic [6:0] trim_code,
  input wire logic       test_mode,
  input wire logic       crystal_select,
  input wire logic       prescaler_clear,
  input wire logic       seconds_zero,
  input wire logic       minute_inc,
  input wire logic       irq_out_n,
  input wire logic       crystal_clock_out
);
  default clocking @(posedge clk); endclocking
  default disable iff (!rst_n);
  // Reads are combinational, so these views match the register contents exactly.
  wire seconds_round_adjust  = reg_we && reg_addr == 4'hF && reg_wdata[4];
  wire rd_e = reg_addr == 4'hE;
  wire rd_f = reg_addr == 4'hF;

  a_adjust_pulse: assert property (seconds_round_adjust |=> prescaler_clear && seconds_zero)
    else $error("adjust pulses missing");
  a_minute_bump: assert property (seconds_round_adjust && sec_value >= 8'h30 |=> minute_inc)
    else $error("minute step missing");
  a_minute_keep: assert property (seconds_round_adjust && sec_value < 8'h30 |=> !minute_inc)
    else $error("minute stepped early");
  a_halt_clears: assert property (rd_f && reg_rdata[4] |=>
    !test_mode && !crystal_select && trim_code == 7'h00) else $error("config kept in halt");
  a_flag_low: assert property (rd_f && reg_rdata[2] |-> !irq_out_n)
    else $error("flag set with pin high");
  a_fixed_low: assert property ((rd_e && reg_rdata[2:0] == 3'h1) [*3] |-> !irq_out_n)
    else $error("fixed low not held");
  a_quiet_off: assert property ((rd_e && reg_rdata == 8'h00) [*3] |-> irq_out_n)
    else $error("pin low with no source");
  a_clock_off: assert property (rd_f && reg_rdata[3] |=> !crystal_clock_out)
    else $error("clock out not stopped");
  a_level_fall: assert property (rd_e && reg_rdata[2:0] == 3'h4 && sec_tick |->
    ##[1:60] !irq_out_n) else $error("level fall missing");
endmodule

bind rtc_control_and_interrupt rtc_ctrl_asserts u_rtc_ctrl_asserts (
  .clk               (clk),
  .rst_n             (rst_n),
  .reg_addr          (reg_addr),
  .reg_wdata         (reg_wdata),
  .reg_we            (reg_we),
  .reg_rdata         (reg_rdata),
  .sec_tick          (sec_tick),
  .sec_value         (sec_value),
  .trim_code         (trim_code),
  .test_mode         (test_mode),
  .crystal_select    (crystal_select),
  .prescaler_clear   (prescaler_clear),
  .seconds_zero      (seconds_zero),
  .minute_inc        (minute_inc),
  .irq_out_n         (irq_out_n),
  .crystal_clock_out (crystal_clock_out)
);
`default_nettype wire

// ===== testbench/rtc_host.sv
`timescale 1ns/1ps
`default_nettype none
module rtc_host (
  // Clock.
  input  wire logic       clk,
  // Register port toward the block.
  output var  logic [3:0] reg_addr,
  output var  logic [7:0] reg_wdata,
  output var  logic       reg_we
);
  // Idle port at time zero.
  initial begin
    reg_addr = 4'h0;
    reg_wdata = 8'h00;
    reg_we = 1'b0;
  end
  // One write, held over the taking edge; released data is inverted so it never looks valid.
  task automatic wr(input logic [3:0] a, input logic [7:0] d);
    @(negedge clk);
    reg_addr = a;
    reg_wdata = d;
    reg_we = 1'b1;
    @(negedge clk);
    reg_we = 1'b0;
    reg_wdata = ~d;
  endtask
  // Points the read address; the answer is combinational.
  task automatic pt(input logic [3:0] a);
    @(negedge clk);
    reg_addr = a;
  endtask
endmodule
`default_nettype wire

// ===== testbench/rtc_control_and_interrupt_tb.sv
`timescale 1ns/1ps
`default_nettype none
module rtc_control_and_interrupt_tb;
  // Block inputs and outputs, named as its ports, plus the test's own lf, ob and sv.
  logic clk, rst_n, xtal_in, osc_running, sec_tick, alarm_one_match, alarm_two_match, reg_we;
  logic hour_24_mode, crystal_select, test_mode, prescaler_clear, seconds_zero, minute_inc;
  logic irq_out_n, crystal_clock_out;
  logic [3:0] reg_addr;
  logic [7:0] reg_wdata, reg_rdata, sec_value, lf, ob, sv[4];
  logic [7:0] min_value, hour_value, day_value;
  logic [6:0] trim_code;
  // Notes: bit 8 selects the pin picture over read data.
  logic [8:0] exq[$];
  logic [8:0] e;
  int         fails, checks_done;

  rtc_host u_rtc_host (
    .clk       (clk),
    .reg_addr  (reg_addr),
    .reg_wdata (reg_wdata),
    .reg_we    (reg_we)
  );
  rtc_control_and_interrupt u_rtc_control_and_interrupt (
    .clk               (clk),
    .rst_n             (rst_n),
    .reg_addr          (reg_addr),
    .reg_wdata         (reg_wdata),
    .reg_we            (reg_we),
    .reg_rdata         (reg_rdata),
    .xtal_in           (xtal_in),
    .osc_running       (osc_running),
    .sec_tick          (sec_tick),
    .sec_value         (sec_value),
    .min_value         (min_value),
    .hour_value        (hour_value),
    .day_value         (day_value),
    .alarm_one_match   (alarm_one_match),
    .alarm_two_match   (alarm_two_match),
    .hour_24_mode      (hour_24_mode),
    .crystal_select    (crystal_select),
    .trim_code         (trim_code),
    .test_mode         (test_mode),
    .prescaler_clear   (prescaler_clear),
    .seconds_zero      (seconds_zero),
    .minute_inc        (minute_inc),
    .irq_out_n         (irq_out_n),
    .crystal_clock_out (crystal_clock_out)
  );

  // System clock and a fast crystal stand-in so the lag stays short.
  initial begin
    clk = 1'b0;
    forever #10 clk = ~clk;
  end
  // The crystal stand-in moves on rising clock edges, unlike every other input.
  initial begin
    #10;
    forever #80 xtal_in = ~xtal_in;
  end

  function automatic logic [7:0] lfsr(input logic [7:0] s);
    return {s[6:0], s[7] ^ s[5] ^ s[4] ^ s[3]};
  endfunction
  task automatic chk(input logic s, input logic [7:0] x);
    exq.push_back({s, x});
    @(negedge clk);
  endtask
  // Bounded wait on the pin, then the pin picture goes to the monitor.
  task automatic wirq(input logic v);
    for (int i = 0; i < 100 && irq_out_n !== v; i++) @(negedge clk);
    chk(1'b1, {v, 7'h04});
  endtask
  task automatic tick();
    @(negedge clk) sec_tick = 1'b1;
    @(negedge clk) sec_tick = 1'b0;
  endtask
  task automatic report_and_stop();
    $display("checks %0d mismatches %0d", checks_done, fails);
    if (fails == 0 && checks_done > 0) $display("SIMULATION PASSED");
    else $display("SIMULATION FAILED");
    $finish;
  endtask

  // Sampled before the edge lands, so the value seen is that of the cycle just ended.
  always @(posedge clk) begin
    if (exq.size() > 0) begin
      e = exq.pop_front();
      ob = e[8] ? {irq_out_n, minute_inc, seconds_zero, prescaler_clear, 1'b0,
                   hour_24_mode, test_mode, crystal_select} : reg_rdata;
      checks_done++;
      if (ob !== e[7:0]) begin
        fails++;
        $display("wrong value %s expected %h seen %h", e[8] ? "pins" : "reg_rdata", e[7:0], ob);
      end
    end
  end

  // A hang is cut well past the expected run of a few hundred cycles.
  initial begin
    #1000000;
    fails++;
    report_and_stop();
  end

  initial begin
    rst_n = 1'b0;
    xtal_in = 1'b0;
    osc_running = 1'b1;
    sec_tick = 1'b0;
    alarm_one_match = 1'b0;
    alarm_two_match = 1'b0;
    sec_value = 8'h00;
    min_value = 8'h00;
    hour_value = 8'h00;
    day_value = 8'h01;
    lf = 8'h47;
    sv = '{8'h29, 8'h30, 8'h59, 8'h00};
    repeat (12) @(posedge clk);
    @(negedge clk) rst_n = 1'b1;
    u_rtc_host.pt(4'hF);
    chk(1'b0, 8'h10);
    u_rtc_host.wr(4'h7, 8'hFF);
    chk(1'b0, 8'h00);
    // Hour format first; this write also ends the halt.
    u_rtc_host.wr(4'hF, 8'h20);
    chk(1'b0, 8'h20);
    lf = lfsr(lf);
    u_rtc_host.wr(4'h7, lf);
    chk(1'b0, lf);
    chk(1'b1, {7'h42, lf[7]});
    u_rtc_host.wr(4'h7, 8'h00);
    // Rounding on both sides of the half minute, boundaries first.
    lf = lfsr(lf);
    sv[3] = {1'b0, 3'(lf[6:4] % 6), 4'(lf[3:0] % 10)};
    foreach (sv[i]) begin
      sec_value = sv[i];
      u_rtc_host.wr(4'hF, 8'h30);
      chk(1'b1, {1'b1, sv[i] >= 8'h30, 6'h34});
      chk(1'b1, 8'h84);
    end
    // Level codes with all counters at their match point; test bit kept clear.
    sec_value = 8'h00;
    for (int c = 4; c < 8; c++) begin
      u_rtc_host.wr(4'hE, 8'(c));
      tick();
      wirq(1'b0);
      u_rtc_host.wr(4'hF, 8'h24);
      chk(1'b0, 8'h24);
      u_rtc_host.wr(4'hF, 8'h20);
      wirq(1'b1);
    end
    // Codes 5 to 7 each stay quiet when one of their counters is off the match point.
    for (int i = 0; i < 4; i++) begin
      sec_value = (i == 0) ? 8'h01 : 8'h00;
      min_value = (i == 1) ? 8'h01 : 8'h00;
      hour_value = (i == 2) ? 8'h12 : 8'h00;
      day_value = (i == 3) ? 8'h02 : 8'h01;
      u_rtc_host.wr(4'hE, (i < 2) ? 8'(i + 5) : 8'h07);
      tick();
      repeat (60) @(negedge clk);
      chk(1'b1, 8'h84);
    end
    // Pulse codes: a count-up restarts the phase, so the pin waits out the lag.
    for (int c = 2; c < 4; c++) begin
      u_rtc_host.wr(4'hE, 8'(c));
      tick();
      @(negedge clk);
      chk(1'b1, 8'h84);
      wirq(1'b0);
    end
    u_rtc_host.wr(4'hE, 8'h01);
    wirq(1'b0);
    u_rtc_host.wr(4'hE, 8'h00);
    wirq(1'b1);
    // Both alarms hit together, only the first one enabled.
    u_rtc_host.wr(4'hE, 8'h80);
    @(negedge clk) alarm_one_match = 1'b1;
    alarm_two_match = 1'b1;
    @(negedge clk) alarm_one_match = 1'b0;
    alarm_two_match = 1'b0;
    wirq(1'b0);
    u_rtc_host.wr(4'hF, 8'h23);
    chk(1'b0, 8'h22);
    u_rtc_host.wr(4'hF, 8'h20);
    wirq(1'b1);
    u_rtc_host.wr(4'hF, 8'h28);
    repeat (4) @(negedge clk);
    // Oscillator stop raises the halt and wipes the configuration except the hour format.
    osc_running = 1'b0;
    repeat (8) @(negedge clk);
    u_rtc_host.pt(4'hF);
    chk(1'b0, 8'h30);
    u_rtc_host.pt(4'hE);
    chk(1'b0, 8'h00);
    repeat (2) @(negedge clk);
    report_and_stop();
  end
endmodule
`default_nettype wire
